// >>> core/vsta_pkg.sv
// Constants shared by the sync timing adjust block: register map, fields, resets, timing.
package vsta_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] VSTA_OFS_CMAP = 8'h4A;
    localparam logic [7:0] VSTA_OFS_FEND = 8'h50;
    localparam logic [7:0] VSTA_OFS_LEND = 8'h51;
    localparam logic [7:0] VSTA_OFS_START = 8'h52;
    localparam logic [7:0] VSTA_OFS_POL = 8'h53;
    localparam logic [7:0] VSTA_OFS_STATUS = 8'h5F;

    // ************************************************************
    // Reset values and implemented-bit masks
    // ************************************************************
    localparam logic [7:0] VSTA_RST_CMAP = 8'h1B;
    localparam logic [7:0] VSTA_RST_FEND = 8'h08;
    localparam logic [7:0] VSTA_RST_LEND = 8'h08;
    localparam logic [7:0] VSTA_RST_START = 8'h00;
    localparam logic [7:0] VSTA_RST_POL = 8'h0C;
    localparam logic [7:0] VSTA_MASK_FEND = 8'h1F;
    localparam logic [7:0] VSTA_MASK_LEND = 8'h0F;
    localparam logic [7:0] VSTA_MASK_POL = 8'h7F;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int VSTA_CH0_LSB = 6;
    localparam int VSTA_CH1_LSB = 4;
    localparam int VSTA_CH2_LSB = 2;
    localparam int VSTA_CH3_LSB = 0;
    localparam int VSTA_FSTART_LSB = 4;
    localparam int VSTA_LSTART_LSB = 0;
    localparam int VSTA_FSTYLE_BIT = 5;
    localparam int VSTA_LSTYLE_BIT = 4;
    localparam int VSTA_ST_FSYNC_BIT = 0;
    localparam int VSTA_ST_LSYNC_BIT = 1;
    localparam int VSTA_ST_FULL_BIT = 2;

    // ************************************************************
    // Timing in pixel-clock steps, FIFO depth and pixel data width
    // ************************************************************
    localparam int VSTA_END_BASE = 8;
    localparam int VSTA_MAX_ADV = 15;
    localparam int VSTA_FEND_MAX = 23;
    localparam int VSTA_LEND_MAX = 7;
    localparam int VSTA_PULSE_LEN = 4;
    localparam int VSTA_FIFO_DEPTH = 4;
    localparam int VSTA_DATA_W = 10;

endpackage : vsta_pkg

// >>> core/vsta_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and registered flags.
`timescale 1ns/1ns
module vsta_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic full_q;
    logic empty_q;
    logic push;
    logic pop;

    assign push = in_valid && !full_q;
    assign pop = out_ready && !empty_q;
    assign out_valid = !empty_q;
    assign out_data = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // Flags are flops so the ready seen by the source is glitch free
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            in_ready <= 1'b1;
        end else begin
            count_q <= count_d;
            full_q <= (count_d == DEPTH_C);
            in_ready <= (count_d != DEPTH_C);
            empty_q <= (count_d == '0);
        end
    end

    a_fifo_no_overfill: assert property (@(posedge ref_clk) disable iff (rst)
        full_q |-> (count_q == DEPTH_C))
        else $error("fifo full flag without full count");

endmodule : vsta_fifo

// >>> core/vsta_top.sv
// Sync timing adjust: register file, sync edge shaping and aligned pixel path.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module vsta_top
    import vsta_pkg::*;
#(
    parameter int DATA_W = VSTA_DATA_W,
    parameter int FIFO_DEPTH = VSTA_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic [DATA_W-1:0] pix_data,
    input wire logic pix_valid,
    input wire logic pix_frame_active,
    input wire logic pix_row_active,
    output logic pix_ready,
    output logic [DATA_W-1:0] vid_data,
    output logic vid_valid,
    output logic frame_sync,
    output logic line_sync,
    input wire logic cap_ready,
    output logic [1:0] chan0_map,
    output logic [1:0] chan1_map,
    output logic [1:0] chan2_map,
    output logic [1:0] chan3_map
);
    localparam int BASE = VSTA_MAX_ADV;
    localparam int FLEN = BASE + VSTA_FEND_MAX + 1;
    localparam int LLEN = BASE + VSTA_LEND_MAX + 1;
    localparam int FW = DATA_W + 2;
    localparam logic [2:0] PULSE_LAST = 3'(VSTA_PULSE_LEN - 1);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Codes below the base are reserved; treat them as no delay
    function automatic logic [4:0] end_extra(input logic [4:0] code, input logic [4:0] cap);
        logic [4:0] ext;
        ext = (code < 5'(VSTA_END_BASE)) ? 5'h00 : 5'(code - 5'(VSTA_END_BASE));
        return (ext > cap) ? cap : ext;
    endfunction : end_extra

    function automatic logic pick(input logic [FLEN-1:0] vec, input int idx);
        return vec[idx];
    endfunction : pick

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0] cmap_q;
    logic [7:0] fend_q;
    logic [7:0] lend_q;
    logic [7:0] start_q;
    logic [7:0] pol_q;
    logic [7:0] rdata_d;
    logic fifo_full;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmap_q <= VSTA_RST_CMAP;
            fend_q <= VSTA_RST_FEND;
            lend_q <= VSTA_RST_LEND;
            start_q <= VSTA_RST_START;
            pol_q <= VSTA_RST_POL;
        end else if (reg_we) begin
            if (reg_addr == VSTA_OFS_CMAP) begin
                cmap_q <= reg_wdata;
            end else if (reg_addr == VSTA_OFS_FEND) begin
                fend_q <= reg_wdata & VSTA_MASK_FEND;
            end else if (reg_addr == VSTA_OFS_LEND) begin
                lend_q <= reg_wdata & VSTA_MASK_LEND;
            end else if (reg_addr == VSTA_OFS_START) begin
                start_q <= reg_wdata;
            end else if (reg_addr == VSTA_OFS_POL) begin
                pol_q <= reg_wdata & VSTA_MASK_POL;
            end
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr == VSTA_OFS_CMAP) begin
            rdata_d = cmap_q;
        end else if (reg_addr == VSTA_OFS_FEND) begin
            rdata_d = fend_q;
        end else if (reg_addr == VSTA_OFS_LEND) begin
            rdata_d = lend_q;
        end else if (reg_addr == VSTA_OFS_START) begin
            rdata_d = start_q;
        end else if (reg_addr == VSTA_OFS_POL) begin
            rdata_d = pol_q;
        end else if (reg_addr == VSTA_OFS_STATUS) begin
            rdata_d[VSTA_ST_FSYNC_BIT] = frame_sync;
            rdata_d[VSTA_ST_LSYNC_BIT] = line_sync;
            rdata_d[VSTA_ST_FULL_BIT] = fifo_full;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_re ? rdata_d : 8'h00;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan0_map <= VSTA_RST_CMAP[VSTA_CH0_LSB +: 2];
            chan1_map <= VSTA_RST_CMAP[VSTA_CH1_LSB +: 2];
            chan2_map <= VSTA_RST_CMAP[VSTA_CH2_LSB +: 2];
            chan3_map <= VSTA_RST_CMAP[VSTA_CH3_LSB +: 2];
        end else begin
            chan0_map <= cmap_q[VSTA_CH0_LSB +: 2];
            chan1_map <= cmap_q[VSTA_CH1_LSB +: 2];
            chan2_map <= cmap_q[VSTA_CH2_LSB +: 2];
            chan3_map <= cmap_q[VSTA_CH3_LSB +: 2];
        end
    end

    // ************************************************************
    // Input FIFO
    // ************************************************************
    logic [FW-1:0] fifo_out;
    logic fifo_valid;
    logic step;
    logic in_frame;
    logic in_row;
    logic [DATA_W-1:0] in_data;

    vsta_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data({pix_frame_active, pix_row_active, pix_data}),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(cap_ready)
    );

    assign fifo_full = !pix_ready;
    // One step is one pixel-clock slot; a stalled receiver freezes all timing
    assign step = fifo_valid && cap_ready;
    assign in_frame = fifo_out[FW-1];
    assign in_row = fifo_out[FW-2];
    assign in_data = fifo_out[DATA_W-1:0];

    // ************************************************************
    // Sync source: level or stretched end pulse
    // ************************************************************
    logic frame_prev_q;
    logic row_prev_q;
    logic [2:0] fcnt_q;
    logic [2:0] lcnt_q;
    logic frame_eof;
    logic row_eol;
    logic frame_src;
    logic line_src;
    logic frame_style;
    logic line_style;

    assign frame_style = pol_q[VSTA_FSTYLE_BIT];
    assign line_style = pol_q[VSTA_LSTYLE_BIT];
    assign frame_eof = frame_prev_q && !in_frame;
    assign row_eol = row_prev_q && !in_row;
    assign frame_src = frame_style ? (frame_eof || fcnt_q != 3'h0) : in_frame;
    assign line_src = line_style ? (row_eol || lcnt_q != 3'h0) : in_row;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_prev_q <= 1'b0;
            row_prev_q <= 1'b0;
            fcnt_q <= 3'h0;
            lcnt_q <= 3'h0;
        end else if (step) begin
            frame_prev_q <= in_frame;
            row_prev_q <= in_row;
            if (frame_style && frame_eof) begin
                fcnt_q <= PULSE_LAST;
            end else if (fcnt_q != 3'h0) begin
                fcnt_q <= fcnt_q - 1'b1;
            end
            if (line_style && row_eol) begin
                lcnt_q <= PULSE_LAST;
            end else if (lcnt_q != 3'h0) begin
                lcnt_q <= lcnt_q - 1'b1;
            end
        end
    end

    // ************************************************************
    // Delay lines and edge shaping
    // ************************************************************
    // Everything is delayed by the largest advance, so an earlier start is an earlier tap
    logic [FLEN-1:0] fsr_q;
    logic [LLEN-1:0] lsr_q;
    logic [DATA_W-1:0] dpipe_q [0:BASE];
    logic [BASE:0] vpipe_q;
    logic [3:0] fadv;
    logic [3:0] ladv;
    logic [4:0] fext;
    logic [4:0] lext;
    logic f_start_bit;
    logic f_end_bit;
    logic l_start_bit;
    logic l_end_bit;

    assign fadv = start_q[VSTA_FSTART_LSB +: 4];
    assign ladv = start_q[VSTA_LSTART_LSB +: 4];
    assign fext = end_extra(fend_q[4:0], 5'(VSTA_FEND_MAX));
    assign lext = end_extra(lend_q[4:0], 5'(VSTA_LEND_MAX));
    assign f_start_bit = pick(fsr_q, BASE - int'(fadv));
    assign f_end_bit = pick(fsr_q, BASE + int'(fext));
    assign l_start_bit = pick(FLEN'(lsr_q), BASE - int'(ladv));
    assign l_end_bit = pick(FLEN'(lsr_q), BASE + int'(lext));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fsr_q <= '0;
            lsr_q <= '0;
            vpipe_q <= '0;
        end else if (step) begin
            fsr_q <= {fsr_q[FLEN-2:0], frame_src};
            lsr_q <= {lsr_q[LLEN-2:0], line_src};
            vpipe_q <= {vpipe_q[BASE-1:0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (step) begin
            dpipe_q[0] <= in_data;
            for (int i = 1; i <= BASE; i++) begin
                dpipe_q[i] <= dpipe_q[i-1];
            end
        end
    end

    // Stretching on both sides assumes gaps wider than advance plus delay
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_sync <= 1'b0;
            line_sync <= 1'b0;
            vid_valid <= 1'b0;
            vid_data <= '0;
        end else begin
            vid_valid <= step && vpipe_q[BASE];
            if (step) begin
                frame_sync <= f_start_bit || f_end_bit;
                line_sync <= l_start_bit || l_end_bit;
                vid_data <= dpipe_q[BASE];
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_frame_eof;
        step && frame_style && frame_eof;
    endsequence

    sequence s_row_eol;
        step && line_style && row_eol;
    endsequence

    a_cmap_fields: assert property (@(posedge ref_clk) disable iff (rst)
        reg_we && reg_addr == VSTA_OFS_CMAP |=> ##1 chan0_map == $past(reg_wdata[7:6], 2)
            && chan3_map == $past(reg_wdata[1:0], 2))
        else $error("color map fields misplaced");

    a_frame_pulse_four: assert property (@(posedge ref_clk) disable iff (rst)
        s_frame_eof |=> fsr_q[0] && fcnt_q == PULSE_LAST)
        else $error("frame pulse not started for four steps");

    a_line_pulse_four: assert property (@(posedge ref_clk) disable iff (rst)
        s_row_eol |=> lsr_q[0] && lcnt_q == PULSE_LAST)
        else $error("line pulse not started for four steps");

    a_frame_level_follow: assert property (@(posedge ref_clk) disable iff (rst)
        step && !frame_style |=> fsr_q[0] == $past(in_frame))
        else $error("frame level does not follow readout");

    a_line_level_follow: assert property (@(posedge ref_clk) disable iff (rst)
        step && !line_style |=> lsr_q[0] == $past(in_row))
        else $error("line level does not follow row");

    a_frame_end_tap: assert property (@(posedge ref_clk) disable iff (rst)
        step && f_end_bit |=> frame_sync)
        else $error("frame sync ended before delayed edge");

    a_line_end_tap: assert property (@(posedge ref_clk) disable iff (rst)
        step && l_end_bit |=> line_sync)
        else $error("line sync ended before delayed edge");

    a_frame_start_tap: assert property (@(posedge ref_clk) disable iff (rst)
        step && f_start_bit |=> frame_sync)
        else $error("frame sync not advanced");

    a_line_idle_low: assert property (@(posedge ref_clk) disable iff (rst)
        step && !l_start_bit && !l_end_bit |=> !line_sync)
        else $error("line sync active outside its window");

    a_hold_on_stall: assert property (@(posedge ref_clk) disable iff (rst)
        !step |=> $stable(frame_sync) && $stable(line_sync) && !vid_valid)
        else $error("sync moved without a pixel step");

    a_rdata_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
        reg_re && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

endmodule : vsta_top

// >>> sim/vsta_capture_model.sv
// Capture receiver model: paces cap_ready and records every output step.
`timescale 1ns/1ns
module vsta_capture_model #(
    parameter int DATA_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall_en,
    input wire logic hold,
    input wire logic [DATA_W-1:0] vid_data,
    input wire logic vid_valid,
    input wire logic frame_sync,
    input wire logic line_sync,
    output logic cap_ready
);
    logic [1:0] pace_q;
    logic [DATA_W-1:0] got_data [$];
    logic got_fs [$];
    logic got_ls [$];

    // Pausing every fourth cycle shows whether sync timing counts steps rather than cycles
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pace_q <= 2'h0;
        end else begin
            pace_q <= pace_q + 2'h1;
        end
    end
    assign cap_ready = !hold && !(stall_en && pace_q == 2'h3);

    always @(posedge ref_clk) begin
        if (rst) begin
            got_data.delete();
            got_fs.delete();
            got_ls.delete();
        end else if (vid_valid) begin
            got_data.push_back(vid_data);
            got_fs.push_back(frame_sync);
            got_ls.push_back(line_sync);
        end
    end
endmodule : vsta_capture_model

// >>> sim/test_video_sync_timing_adjust.sv
// Testbench: register access, color map, sync shaping in both modes, FIFO back-pressure.
`timescale 1ns/1ns
module test_video_sync_timing_adjust import vsta_pkg::*;;
    localparam int N = 128;
    // Pipe latency is the largest advance plus one step
    localparam int NS = N - VSTA_MAX_ADV - 1;
    localparam logic [7:0] POL [4] = '{8'h0C, 8'h3C, 8'h0C, 8'h3C};
    localparam logic [7:0] STA [4] = '{8'h00, 8'h00, 8'h32, 8'hFF};
    localparam logic [7:0] FEN [4] = '{8'h08, 8'h08, 8'h0B, 8'h1F};
    localparam logic [7:0] LEN [4] = '{8'h08, 8'h08, 8'h09, 8'h0F};
    logic ref_clk, rst, reg_we, reg_re, pix_valid, fr_act, row_act, cap_ready, vid_valid;
    logic frame_sync, line_sync, pix_ready, stall_en, hold;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [9:0] pix_data, vid_data;
    logic [1:0] chan0_map, chan1_map, chan2_map, chan3_map;
    int fails, n_compared, cycles;
    int f_adv, l_adv, f_ext, l_ext;
    bit f_pulse, l_pulse;

    vsta_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .pix_data(pix_data), .pix_valid(pix_valid),
        .pix_frame_active(fr_act), .pix_row_active(row_act), .pix_ready(pix_ready), .vid_data(vid_data),
        .vid_valid(vid_valid), .frame_sync(frame_sync), .line_sync(line_sync), .cap_ready(cap_ready),
        .chan0_map(chan0_map), .chan1_map(chan1_map), .chan2_map(chan2_map), .chan3_map(chan3_map));
    vsta_capture_model cap (.ref_clk(ref_clk), .rst(rst), .stall_en(stall_en), .hold(hold),
        .vid_data(vid_data), .vid_valid(vid_valid), .frame_sync(frame_sync), .line_sync(line_sync),
        .cap_ready(cap_ready));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask : do_reset

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
        @(posedge ref_clk);
    endtask : reg_wr

    // Read data stands only in the cycle after the strobe, then returns to zero
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        @(posedge ref_clk);
        check("reg_rdata", 16'(exp), 16'(reg_rdata));
        @(posedge ref_clk);
        check("reg_rdata_idle", 16'h0000, 16'(reg_rdata));
    endtask : reg_chk

    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        reg_wr(a, d);
        reg_chk(a, exp);
    endtask : wr_rd

    task automatic chk_map(input logic [7:0] exp);
        check("chan_maps", 16'(exp), 16'({chan0_map, chan1_map, chan2_map, chan3_map}));
    endtask : chk_map

    // Frame spans words 20..83; rows of 8 words with gaps of 8 inside it
    function automatic bit lvl(int i, bit line);
        bit f;
        f = (i >= 20 && i < 84);
        return line ? (f && ((i - 20) % 16 < 8)) : f;
    endfunction : lvl

    function automatic bit src(int k, bit line, bit pulse);
        if (!pulse) begin
            return lvl(k, line);
        end
        for (int j = k - 3; j <= k; j++) begin
            if (lvl(j - 1, line) && !lvl(j, line)) begin
                return 1'b1;
            end
        end
        return 1'b0;
    endfunction : src

    function automatic bit exp_sync(int k, bit line);
        if (line) begin
            return src(k + l_adv, 1'b1, l_pulse) | src(k - l_ext, 1'b1, l_pulse);
        end
        return src(k + f_adv, 1'b0, f_pulse) | src(k - f_ext, 1'b0, f_pulse);
    endfunction : exp_sync

    task automatic drive(input int i);
        pix_data <= 10'(i);
        fr_act <= lvl(i, 1'b0);
        row_act <= lvl(i, 1'b1);
    endtask : drive

    task automatic stream(input bit fill);
        int i;
        int cyc;
        i = 0;
        cyc = 0;
        hold <= fill;
        pix_valid <= 1'b1;
        drive(0);
        while (i < N) begin
            @(posedge ref_clk);
            cyc++;
            if (pix_ready === 1'b1) begin
                i++;
                drive(i);
            end
            if (fill && cyc == 10) begin
                check("fifo_taken", 16'(VSTA_FIFO_DEPTH), 16'(i));
                check("pix_ready_full", 16'h0000, 16'(pix_ready));
                hold <= 1'b0;
            end
        end
        pix_valid <= 1'b0;
        cyc = 0;
        while (cap.got_data.size() < NS && cyc < 400) begin
            @(posedge ref_clk);
            cyc++;
        end
        check("samples", 16'(NS), 16'(cap.got_data.size()));
        for (int k = 0; k < NS && k < cap.got_data.size(); k++) begin
            check("vid_data", 16'(k), 16'(cap.got_data[k]));
            check("frame_sync", 16'(exp_sync(k, 1'b0)), 16'(cap.got_fs[k]));
            check("line_sync", 16'(exp_sync(k, 1'b1)), 16'(cap.got_ls[k]));
        end
    endtask : stream

    // ************************************************************
    // Clock, timeout and main sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        rst = 1'b1;
        reg_we = 1'b0;
        reg_re = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        pix_valid = 1'b0;
        pix_data = 10'h000;
        fr_act = 1'b0;
        row_act = 1'b0;
        stall_en = 1'b0;
        hold = 1'b0;
        do_reset();
        chk_map(8'h1B);
        reg_chk(VSTA_OFS_CMAP, 8'h1B);
        reg_chk(VSTA_OFS_FEND, 8'h08);
        reg_chk(VSTA_OFS_LEND, 8'h08);
        reg_chk(VSTA_OFS_START, 8'h00);
        reg_chk(VSTA_OFS_POL, 8'h0C);
        reg_chk(8'h00, 8'h00);
        reg_chk(VSTA_OFS_STATUS, 8'h00);
        reg_wr(VSTA_OFS_STATUS, 8'hFF);
        reg_chk(VSTA_OFS_STATUS, 8'h00);
        wr_rd(VSTA_OFS_POL, 8'hFF, 8'h7F);
        reg_wr(8'h60, 8'hA5);
        reg_chk(8'h60, 8'h00);
        wr_rd(VSTA_OFS_FEND, 8'hFF, 8'h1F);
        wr_rd(VSTA_OFS_LEND, 8'hFF, 8'h0F);
        wr_rd(VSTA_OFS_CMAP, 8'hE4, 8'hE4);
        chk_map(8'hE4);
        wr_rd(VSTA_OFS_CMAP, 8'h00, 8'h00);
        chk_map(8'h00);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            do_reset();
            stall_en <= (c == 1 || c == 2);
            wr_rd(VSTA_OFS_POL, POL[c], POL[c]);
            wr_rd(VSTA_OFS_START, STA[c], STA[c]);
            wr_rd(VSTA_OFS_FEND, FEN[c], FEN[c]);
            wr_rd(VSTA_OFS_LEND, LEN[c], LEN[c]);
            f_pulse = POL[c][VSTA_FSTYLE_BIT];
            l_pulse = POL[c][VSTA_LSTYLE_BIT];
            f_adv = int'(STA[c][7:4]);
            l_adv = int'(STA[c][3:0]);
            f_ext = int'(FEN[c]) - VSTA_END_BASE;
            l_ext = int'(LEN[c]) - VSTA_END_BASE;
            stream(c == 1);
            $display("test sync config %0d done", c);
        end
        conclude();
    end
endmodule : test_video_sync_timing_adjust
